// [core/cfs_pkg.sv]
// cfs_pkg: shared constants of the fetch sequencer and its ALU.
// assumes: instruction word layout and special register addresses below.
package cfs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PC_W  = 10;  // program counter bits
  localparam int PM_W  = 14;  // program word bits
  localparam int DW    = 8;   // data path bits
  localparam int DMA_W = 7;   // data memory address bits
  localparam int HI_W  = 2;   // high program counter bits
  localparam int TBH_W = PM_W - DW; // table word upper bits
  localparam int ST_W  = 4;   // status flag bits
  localparam int NPH   = 4;   // phases per instruction cycle

  // ---------------------------------------------------------------
  // phases and timing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cfs_phase_t;
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------
  // vectors and reset values
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] RESET_VEC  = 10'h000;
  localparam logic [PC_W-1:0] INT_VEC    = 10'h004;
  localparam logic [HI_W-1:0] LAST_PAGE  = 2'h3;
  localparam logic [DW-1:0]   RST_BYTE   = 8'h00;
  localparam logic [ST_W-1:0] RST_STATUS = 4'h0;
  localparam logic [PM_W-1:0] RST_INSN   = 14'h1000; // no-operation

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI  = 11;
  localparam int OP_LO  = 8;
  localparam int DST_B  = 7;
  localparam logic [1:0] CL_ALU  = 2'h0;
  localparam logic [1:0] CL_MISC = 2'h1;
  localparam logic [1:0] CL_JUMP = 2'h2;
  localparam logic [1:0] CL_CALL = 2'h3;

  // alu operations
  localparam logic [3:0] OP_MOV = 4'h0, OP_ADD = 4'h1, OP_ADC = 4'h2, OP_SUB = 4'h3;
  localparam logic [3:0] OP_SBC = 4'h4, OP_DAA = 4'h5, OP_AND = 4'h6, OP_OR  = 4'h7;
  localparam logic [3:0] OP_XOR = 4'h8, OP_CPL = 4'h9, OP_RR  = 4'hA, OP_RRC = 4'hB;
  localparam logic [3:0] OP_RL  = 4'hC, OP_RLC = 4'hD, OP_INC = 4'hE, OP_DEC = 4'hF;

  // miscellaneous operations
  localparam logic [3:0] MS_NOP = 4'h0, MS_RET = 4'h1, MS_INTERRUPT_RETURN_INSN  = 4'h2, MS_MOVWR = 4'h3;
  localparam logic [3:0] MS_SZ  = 4'h4, MS_SNZ = 4'h5, MS_TABRD = 4'h6, MS_TABLE_READ_LAST_PAGE = 4'h7;
  localparam logic [3:0] MS_TABRDF = 4'h8, MS_MOVLA = 4'h9;

  // ---------------------------------------------------------------
  // special register addresses and status bits
  // ---------------------------------------------------------------
  localparam logic [DMA_W-1:0] A_PCL  = 7'h06;
  localparam logic [DMA_W-1:0] A_TBLP = 7'h07;
  localparam logic [DMA_W-1:0] A_TABLE_POINTER_HIGH = 7'h08;
  localparam logic [DMA_W-1:0] A_TABLE_HIGH_RESULT = 7'h09;
  localparam logic [DMA_W-1:0] A_STAT = 7'h0A;
  localparam int ST_C  = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;

endpackage

// [core/cfs_alu.sv]
// cfs_alu: 8-bit combinational arithmetic and logic unit.
// assumes: caller registers the result and flags on the execute edge.
`timescale 1ns/1ps
module cfs_alu (
  // operation and operands
  input  wire logic [3:0]                 i_op,
  input  wire logic [cfs_pkg::DW-1:0]     i_a,
  input  wire logic [cfs_pkg::DW-1:0]     i_m,
  input  wire logic [cfs_pkg::ST_W-1:0]   i_flags,
  // result
  output logic      [cfs_pkg::DW-1:0]     o_y,
  output logic      [cfs_pkg::ST_W-1:0]   o_flags
);

  // ---------------------------------------------------------------
  // adder and function select
  // ---------------------------------------------------------------
  logic [cfs_pkg::DW-1:0] b;
  logic                   ci;
  logic [cfs_pkg::DW:0]   s9;
  logic [4:0]             h5;
  logic                   cin;

  assign cin = i_flags[cfs_pkg::ST_C];

  // add, subtract, logic, rotate, step and decimal adjust
  always_comb begin
    b  = i_m;
    ci = 1'b0;
    if (i_op == cfs_pkg::OP_ADC) ci = cin;
    if (i_op == cfs_pkg::OP_SUB || i_op == cfs_pkg::OP_SBC) begin
      b  = ~i_m;
      ci = (i_op == cfs_pkg::OP_SUB) ? 1'b1 : cin;
    end
    if (i_op == cfs_pkg::OP_DAA) begin
      b[3:0] = (i_a[3:0] > 4'h9 || i_flags[cfs_pkg::ST_AC]) ? 4'h6 : 4'h0;
      b[7:4] = (i_a[7:4] > 4'h9 || cin) ? 4'h6 : 4'h0;
    end
    s9 = {1'b0, i_a} + {1'b0, b} + {8'h00, ci};
    h5 = {1'b0, i_a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    o_y     = i_m;
    o_flags = i_flags;
    case (i_op)
      cfs_pkg::OP_ADD, cfs_pkg::OP_ADC, cfs_pkg::OP_SUB, cfs_pkg::OP_SBC: begin
        o_y                   = s9[7:0];
        o_flags[cfs_pkg::ST_C]  = s9[8];
        o_flags[cfs_pkg::ST_AC] = h5[4];
        o_flags[cfs_pkg::ST_OV] = (i_a[7] == b[7]) && (s9[7] != i_a[7]);
      end
      cfs_pkg::OP_DAA: begin
        o_y                  = s9[7:0];
        o_flags[cfs_pkg::ST_C] = s9[8] | cin;
      end
      cfs_pkg::OP_AND: o_y = i_a & i_m;
      cfs_pkg::OP_OR:  o_y = i_a | i_m;
      cfs_pkg::OP_XOR: o_y = i_a ^ i_m;
      cfs_pkg::OP_CPL: o_y = ~i_m;
      cfs_pkg::OP_RR:  o_y = {i_m[0], i_m[7:1]};
      cfs_pkg::OP_RL:  o_y = {i_m[6:0], i_m[7]};
      cfs_pkg::OP_RRC: begin
        o_y                  = {cin, i_m[7:1]};
        o_flags[cfs_pkg::ST_C] = i_m[0];
      end
      cfs_pkg::OP_RLC: begin
        o_y                  = {i_m[6:0], cin};
        o_flags[cfs_pkg::ST_C] = i_m[7];
      end
      cfs_pkg::OP_INC: o_y = i_m + 8'h01;
      cfs_pkg::OP_DEC: o_y = i_m - 8'h01;
      default:         o_y = i_m;
    endcase
    o_flags[cfs_pkg::ST_Z] = (o_y == 8'h00);
  end

endmodule // cfs_alu

// [core/cfs_fetch_seq.sv]
// cfs_fetch_seq: four-phase fetch and execute sequencer of an 8-bit core.
// assumes: program and data memory answer within one instruction cycle,
// i_int_req is an enabled interrupt request from the interrupt logic.
`timescale 1ns/1ps
module cfs_fetch_seq #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  // program memory
  output logic      [cfs_pkg::PC_W-1:0]      o_pm_addr,
  input  wire logic [cfs_pkg::PM_W-1:0]      i_pm_data,
  // data memory
  output logic      [cfs_pkg::DMA_W-1:0]     o_dm_raddr,
  input  wire logic [cfs_pkg::DW-1:0]        i_dm_rdata,
  output logic                               o_dm_we,
  output logic      [cfs_pkg::DMA_W-1:0]     o_dm_waddr,
  output logic      [cfs_pkg::DW-1:0]        o_dm_wdata,
  // interrupt logic
  input  wire logic                          i_int_req,
  output logic                               o_int_ack,
  output logic                               o_int_pend,
  // core state
  output logic      [cfs_pkg::NPH-1:0]       o_phase_clocks,
  output logic      [cfs_pkg::PC_W-1:0]      o_pc,
  output logic      [cfs_pkg::DW-1:0]        o_acc,
  output logic      [cfs_pkg::ST_W-1:0]      o_status,
  output logic                               o_stack_full,
  output logic                               o_dummy
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam logic [SPW:0] FULL_CNT = (SPW+1)'(STACK_DEPTH);

  // refuse depths the wrapping pointer cannot serve
  generate
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad
      $error("stack depth must be a power of two of at least 2");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cfs_pkg::cfs_phase_t              phase_r;
  logic [cfs_pkg::NPH-1:0]          ph_r;
  logic [cfs_pkg::PC_W-1:0]         pc_r, pm_addr_r, ir_pc_r, pc_nxt, tab_addr;
  logic [cfs_pkg::PM_W-1:0]         ir_r;
  logic                             dummy_r, tab_busy_r, int_pend_r, int_ack_r;
  logic [cfs_pkg::DMA_W-1:0]        tab_dst_r, dm_waddr_r;
  logic [cfs_pkg::DW-1:0]           acc_r, tblp_r, dm_wdata_r, mval, wr_val, alu_y;
  logic [cfs_pkg::HI_W-1:0]         table_pointer_high_r;
  logic [cfs_pkg::TBH_W-1:0]        table_high_result_r;
  logic [cfs_pkg::ST_W-1:0]         status_r, alu_flags;
  logic                             dm_we_r;
  logic [cfs_pkg::PC_W-1:0]         stk_r [STACK_DEPTH];
  logic [SPW-1:0]                   sp_r;
  logic [SPW:0]                     cnt_r;

  // decode
  logic [1:0]               cls;
  logic [3:0]               op;
  logic [cfs_pkg::DMA_W-1:0] maddr;
  logic last, slot, ack, exe, full;
  logic is_jmp, is_call, is_ret, is_alu, is_misc, skip, tab_start, wr_m, pcl_wr;

  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  // one-hot phase clocks, one pass per instruction cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= cfs_pkg::PH_T1;
      ph_r    <= 4'h1;
    end else begin
      case (phase_r)
        cfs_pkg::PH_T1: phase_r <= cfs_pkg::PH_T2;
        cfs_pkg::PH_T2: phase_r <= cfs_pkg::PH_T3;
        cfs_pkg::PH_T3: phase_r <= cfs_pkg::PH_T4;
        default:        phase_r <= cfs_pkg::PH_T1;
      endcase
      ph_r <= {ph_r[2:0], ph_r[3]};
    end
  end

  // ---------------------------------------------------------------
  // decode of the word in execution
  // ---------------------------------------------------------------
  assign last    = (phase_r == cfs_pkg::PH_T4);
  assign full    = (cnt_r == FULL_CNT);
  assign slot    = last & ~dummy_r & ~tab_busy_r;
  assign ack     = slot & int_pend_r & ~full;
  assign exe     = slot & ~ack;
  assign cls     = ir_r[cfs_pkg::CLS_HI:cfs_pkg::CLS_LO];
  assign op      = ir_r[cfs_pkg::OP_HI:cfs_pkg::OP_LO];
  assign maddr   = ir_r[cfs_pkg::DMA_W-1:0];
  assign is_jmp  = exe & (cls == cfs_pkg::CL_JUMP);
  assign is_call = exe & (cls == cfs_pkg::CL_CALL);
  assign is_alu  = exe & (cls == cfs_pkg::CL_ALU);
  assign is_misc = exe & (cls == cfs_pkg::CL_MISC);
  assign is_ret  = is_misc & (op == cfs_pkg::MS_RET || op == cfs_pkg::MS_INTERRUPT_RETURN_INSN);
  assign skip    = is_misc & ((op == cfs_pkg::MS_SZ && mval == 8'h00) ||
                              (op == cfs_pkg::MS_SNZ && mval != 8'h00));
  assign tab_start = is_misc & (op == cfs_pkg::MS_TABRD || op == cfs_pkg::MS_TABLE_READ_LAST_PAGE ||
                                op == cfs_pkg::MS_TABRDF);
  assign wr_m    = (is_alu & ir_r[cfs_pkg::DST_B]) | (is_misc & op == cfs_pkg::MS_MOVWR);
  assign wr_val  = is_alu ? alu_y : acc_r;
  assign pcl_wr  = wr_m & (maddr == cfs_pkg::A_PCL);

  // operand: low counter byte and table registers are mapped in data space
  always_comb begin
    if (maddr == cfs_pkg::A_PCL)       mval = pc_r[cfs_pkg::DW-1:0];
    else if (maddr == cfs_pkg::A_TBLP) mval = tblp_r;
    else if (maddr == cfs_pkg::A_TABLE_POINTER_HIGH) mval = {6'h00, table_pointer_high_r};
    else if (maddr == cfs_pkg::A_TABLE_HIGH_RESULT) mval = {2'h0, table_high_result_r};
    else if (maddr == cfs_pkg::A_STAT) mval = {4'h0, status_r};
    else                               mval = i_dm_rdata;
  end

  // table address per variant
  always_comb begin
    if (op == cfs_pkg::MS_TABLE_READ_LAST_PAGE)      tab_addr = {cfs_pkg::LAST_PAGE, tblp_r};
    else if (op == cfs_pkg::MS_TABRDF) tab_addr = {table_pointer_high_r, tblp_r};
    else tab_addr = {ir_pc_r[cfs_pkg::PC_W-1:cfs_pkg::DW], tblp_r};
  end

  // next counter value, applied on the edge that opens the first phase
  always_comb begin
    if (tab_busy_r)            pc_nxt = pc_r;
    else if (ack)              pc_nxt = cfs_pkg::INT_VEC;
    else if (is_jmp | is_call) pc_nxt = ir_r[cfs_pkg::PC_W-1:0];
    else if (is_ret)           pc_nxt = stk_r[sp_r - 1'b1];
    else if (pcl_wr)           pc_nxt = {pc_r[cfs_pkg::PC_W-1:cfs_pkg::DW], wr_val};
    else                       pc_nxt = pc_r + 10'h001;
  end

  // ---------------------------------------------------------------
  // alu
  // ---------------------------------------------------------------
  cfs_alu u_alu (
    .i_op    (op),
    .i_a     (acc_r),
    .i_m     (mval),
    .i_flags (status_r),
    .o_y     (alu_y),
    .o_flags (alu_flags)
  );

  // ---------------------------------------------------------------
  // fetch pipeline
  // ---------------------------------------------------------------
  // counter, fetch address and instruction register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_r      <= cfs_pkg::RESET_VEC;
      pm_addr_r <= cfs_pkg::RESET_VEC;
      ir_r      <= cfs_pkg::RST_INSN;
      ir_pc_r   <= cfs_pkg::RESET_VEC;
      dummy_r   <= 1'b1;
    end else if (last) begin
      pc_r      <= pc_nxt;
      pm_addr_r <= tab_start ? tab_addr : pc_nxt;
      if (!tab_busy_r) begin
        ir_r    <= i_pm_data;
        ir_pc_r <= pm_addr_r;
        dummy_r <= ack | is_jmp | is_call | is_ret | skip | pcl_wr;
      end
    end
  end

  // table read: second cycle fetches the table word
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tab_busy_r <= 1'b0;
      tab_dst_r  <= '0;
      table_high_result_r     <= '0;
    end else if (last) begin
      tab_busy_r <= tab_start;
      if (tab_start) tab_dst_r <= maddr;
      if (tab_busy_r) table_high_result_r <= i_pm_data[cfs_pkg::PM_W-1:cfs_pkg::DW];
    end
  end

  // ---------------------------------------------------------------
  // data path registers
  // ---------------------------------------------------------------
  // accumulator and status flags
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_r    <= cfs_pkg::RST_BYTE;
      status_r <= cfs_pkg::RST_STATUS;
    end else begin
      if (is_alu && !ir_r[cfs_pkg::DST_B]) acc_r <= alu_y;
      else if (is_misc && op == cfs_pkg::MS_MOVLA) acc_r <= ir_r[cfs_pkg::DW-1:0];
      if (wr_m && maddr == cfs_pkg::A_STAT) status_r <= wr_val[cfs_pkg::ST_W-1:0];
      else if (is_alu) status_r <= alu_flags;
    end
  end

  // table pointer low and high bytes; writes to the table high result are dropped
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tblp_r <= cfs_pkg::RST_BYTE;
      table_pointer_high_r <= '0;
    end else if (wr_m) begin
      if (maddr == cfs_pkg::A_TBLP) tblp_r <= wr_val;
      if (maddr == cfs_pkg::A_TABLE_POINTER_HIGH) table_pointer_high_r <= wr_val[cfs_pkg::HI_W-1:0];
    end
  end

  // data memory write port, one pulse in the first phase
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dm_we_r    <= 1'b0;
      dm_waddr_r <= '0;
      dm_wdata_r <= '0;
    end else begin
      dm_we_r <= 1'b0;
      if (last && tab_busy_r) begin
        dm_we_r    <= 1'b1;
        dm_waddr_r <= tab_dst_r;
        dm_wdata_r <= i_pm_data[cfs_pkg::DW-1:0];
      end else if (wr_m && maddr != cfs_pkg::A_PCL && maddr != cfs_pkg::A_TBLP &&
                   maddr != cfs_pkg::A_TABLE_POINTER_HIGH && maddr != cfs_pkg::A_TABLE_HIGH_RESULT &&
                   maddr != cfs_pkg::A_STAT) begin
        dm_we_r    <= 1'b1;
        dm_waddr_r <= maddr;
        dm_wdata_r <= wr_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // return stack and interrupt acknowledge
  // ---------------------------------------------------------------
  // wrapping store: a push when full overwrites the oldest entry
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_r  <= '0;
      cnt_r <= '0;
    end else if (is_call || ack) begin
      stk_r[sp_r] <= ack ? ir_pc_r : pc_r;
      sp_r        <= sp_r + 1'b1;
      cnt_r       <= full ? FULL_CNT : cnt_r + 1'b1;
    end else if (is_ret) begin
      sp_r  <= sp_r - 1'b1;
      cnt_r <= (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    end
  end

  // pending flag: a new request wins over the acknowledge clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      int_pend_r <= 1'b0;
      int_ack_r  <= 1'b0;
    end else begin
      int_ack_r <= ack;
      if (i_int_req) int_pend_r <= 1'b1;
      else if (ack)  int_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_pm_addr      = pm_addr_r;
  assign o_dm_raddr     = maddr;
  assign o_dm_we        = dm_we_r;
  assign o_dm_waddr     = dm_waddr_r;
  assign o_dm_wdata     = dm_wdata_r;
  assign o_int_ack      = int_ack_r;
  assign o_int_pend     = int_pend_r;
  assign o_phase_clocks = ph_r;
  assign o_pc           = pc_r;
  assign o_acc          = acc_r;
  assign o_status       = status_r;
  assign o_stack_full   = full;
  assign o_dummy        = dummy_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_phase_walk: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ph_r[0] |=> ph_r[1] ##1 ph_r[2] ##1 ph_r[3] ##1 ph_r[0])
    else $error("phases out of order");
  a_phase_onehot: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $onehot(ph_r) && ph_r[phase_r])
    else $error("phase clocks overlap");
  a_pc_t1_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !last |=> $stable(pc_r))
    else $error("counter moved outside first phase");
  a_pc_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_alu && !pcl_wr) |=> pc_r == $past(pc_r) + 10'h001 && !dummy_r)
    else $error("plain instruction did not step counter");
  a_jump_target: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_jmp |=> dummy_r && pc_r == $past(ir_r[cfs_pkg::PC_W-1:0]) ##4 !dummy_r)
    else $error("jump not two cycles");
  a_pcl_page: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pcl_wr |=> dummy_r && pc_r[cfs_pkg::PC_W-1:cfs_pkg::DW] ==
               $past(pc_r[cfs_pkg::PC_W-1:cfs_pkg::DW]))
    else $error("low byte write left page");
  a_skip_dummy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    skip |=> dummy_r && pc_r == $past(pc_r) + 10'h001)
    else $error("taken skip without dummy");
  a_full_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (slot && int_pend_r && full) |=> !int_ack_r && int_pend_r)
    else $error("acknowledge with full stack");
  a_push_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_call && !full) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("call did not push");
  a_overflow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_call && full) |=> cnt_r == FULL_CNT && pc_r == $past(ir_r[cfs_pkg::PC_W-1:0]))
    else $error("full call not performed");
  a_table_two: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tab_start |=> tab_busy_r [*4] ##1 (!tab_busy_r && dm_we_r))
    else $error("table read not two cycles");

endmodule // cfs_fetch_seq

// [verification/cfs_mem_model.sv]
// cfs_mem_model: program and data memory beside the sequencer.
// assumes: bench loads both arrays before reset is released.
`timescale 1ns/1ps
module cfs_mem_model (
  // clock
  input  wire logic        i_ref_clk,
  // program memory
  input  wire logic [9:0]  i_pm_addr,
  output logic      [13:0] o_pm_data,
  // data memory
  input  wire logic [6:0]  i_dm_raddr,
  output logic      [7:0]  o_dm_rdata,
  input  wire logic        i_dm_we,
  input  wire logic [6:0]  i_dm_waddr,
  input  wire logic [7:0]  i_dm_wdata
);
  logic [13:0] pm [1024];
  logic [7:0]  dm [128];
  // reads answer at once
  assign o_pm_data  = pm[i_pm_addr];
  assign o_dm_rdata = dm[i_dm_raddr];
  // write on strobe
  always @(posedge i_ref_clk) begin
    if (i_dm_we) dm[i_dm_waddr] <= i_dm_wdata;
  end
endmodule // cfs_mem_model

// [verification/tb_top.sv]
// tb_top: self-checking bench for the fetch sequencer.
// assumes: memory model answers within the cycle; 25 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, irq = 1'b0;
  logic [9:0]  pm_addr, pc;
  logic [13:0] pm_data;
  logic [6:0]  dm_raddr, dm_waddr;
  logic [7:0]  dm_rdata, dm_wdata, acc;
  logic [3:0]  ph, stat;
  logic        dm_we, ack, pend, full, dmy;
  int          num_errors = 0, num_checks = 0, ncyc = 0;
  int          wt [128];
  // program as {address, word}
  logic [27:0] prog [15] = '{28'h000_19A5, 28'h001_1320, 28'h002_2010, 28'h010_3040,
    28'h011_1321, 28'h012_2012, 28'h040_1906, 28'h041_1307, 28'h042_1722, 28'h043_0009,
    28'h044_1323, 28'h045_1100, 28'h004_1324, 28'h005_1200, 28'h306_3F1B};
  always #20 clk = ~clk;
  cfs_fetch_seq u_cfs_fetch_seq (.i_ref_clk(clk), .i_rst(rst), .o_pm_addr(pm_addr),
    .i_pm_data(pm_data), .o_dm_raddr(dm_raddr), .i_dm_rdata(dm_rdata), .o_dm_we(dm_we),
    .o_dm_waddr(dm_waddr), .o_dm_wdata(dm_wdata), .i_int_req(irq), .o_int_ack(ack),
    .o_int_pend(pend), .o_phase_clocks(ph), .o_pc(pc), .o_acc(acc), .o_status(stat),
    .o_stack_full(full), .o_dummy(dmy));
  cfs_mem_model u_cfs_mem_model (.i_ref_clk(clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data),
    .i_dm_raddr(dm_raddr), .o_dm_rdata(dm_rdata), .i_dm_we(dm_we), .i_dm_waddr(dm_waddr),
    .i_dm_wdata(dm_wdata));
  // clock count and time of each write
  always @(posedge clk) begin
    ncyc++;
    if (dm_we === 1'b1) wt[dm_waddr] = ncyc;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset state, phase rotation, first advance
  task automatic t_reset();
    check(pc, 10'h000);
    check(full, 1'b0);
    @(negedge clk) rst = 1'b0;
    for (int k = 1; k < 9; k++) begin
      @(negedge clk);
      check(ph, 4'h1 << (k % 4));
      if (k == 4) check(pc, 10'h001);
    end
    $display("test reset done");
  endtask
  // straight code, call, table read, return
  task automatic t_flow();
    repeat (100) @(negedge clk);
    check(u_cfs_mem_model.dm[7'h20], 8'hA5);
    check(u_cfs_mem_model.dm[7'h22], 8'h1B);
    check(u_cfs_mem_model.dm[7'h23], 8'h3F);
    check(u_cfs_mem_model.dm[7'h21], 8'h3F);
    check(16'(wt[7'h23] - wt[7'h20]), 16'd40);
    check(16'(wt[7'h21] - wt[7'h23]), 16'd12);
    check(16'(pc[9:1]), 16'h0009);
    check(acc, 8'h3F);
    $display("test flow done");
  endtask
  // interrupt taken from the idle loop
  task automatic t_irq();
    int n;
    n = 0;
    irq = 1'b1;
    @(negedge clk) irq = 1'b0;
    check(pend, 1'b1);
    while (ack !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    check(ack, 1'b1);
    check(pc, 10'h004);
    check(dmy, 1'b1);
    repeat (40) @(negedge clk);
    check(u_cfs_mem_model.dm[7'h24], 8'h3F);
    check(16'(pc[9:1]), 16'h0009);
    $display("test irq done");
  endtask
  // mid-run reset; pc-low jump, taken skip, add, nine nested calls, interrupt held while full
  task automatic t_stack();
    int n, t0;
    n = 0;
    rst = 1'b1;
    for (int a = 0; a < 24; a++) begin
      u_cfs_mem_model.pm[a] = 14'h1000;
      if (a > 10 && a < 20) u_cfs_mem_model.pm[a] = 14'h3001 + 14'(a); // call a+1
    end
    u_cfs_mem_model.pm[0]  = 14'h1908; // acc = 08
    u_cfs_mem_model.pm[1]  = 14'h1306; // write pc low byte: go to 008
    u_cfs_mem_model.pm[4]  = 14'h1333; // vector: store acc
    u_cfs_mem_model.pm[5]  = 14'h2005; // park
    u_cfs_mem_model.pm[8]  = 14'h1430; // skip if zero, taken
    u_cfs_mem_model.pm[9]  = 14'h1331; // skipped store
    u_cfs_mem_model.pm[10] = 14'h01B2; // add into memory
    u_cfs_mem_model.pm[20] = 14'h1334; // runs after the overflowing call
    u_cfs_mem_model.pm[23] = 14'h1100; // return
    u_cfs_mem_model.dm[7'h32] = 8'hF9;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t0 = ncyc;
    check(pc, 10'h000);
    while (full !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(full, 1'b1);
    irq = 1'b1;
    @(negedge clk) irq = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 100) begin
      check(pend, 1'b1);
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'd35);
    check(pc, 10'h004);
    check(dmy, 1'b1);
    repeat (20) @(negedge clk);
    check(16'(wt[7'h32] - t0), 16'd29);
    check(u_cfs_mem_model.dm[7'h31], 8'h00);
    check(u_cfs_mem_model.dm[7'h32], 8'h01);
    check(stat[cfs_pkg::ST_C], 1'b1);
    check(u_cfs_mem_model.dm[7'h34], 8'h08);
    check(u_cfs_mem_model.dm[7'h33], 8'h08);
    check(acc, 8'h08);
    $display("test stack done");
  endtask
  // load memories, then run tests
  initial begin
    for (int a = 0; a < 1024; a++) u_cfs_mem_model.pm[a] = 14'h1000;
    for (int a = 0; a < 128; a++) u_cfs_mem_model.dm[a] = 8'h00;
    foreach (prog[i]) u_cfs_mem_model.pm[prog[i][25:16]] = prog[i][13:0];
    repeat (20) @(negedge clk);
    t_reset();
    t_flow();
    t_irq();
    t_stack();
    summarize();
  end
  // watchdog
  initial begin
    #(40 * 3000);
    num_errors++;
    summarize();
  end
endmodule // tb_top
